// ===== sefl_pkg.sv
`default_nettype none
package sefl_pkg;
  // Flag positions inside the error status word
  localparam int unsigned SEFL_NFLAG        = 5;
  localparam int unsigned SEFL_BIT_OUTPUT   = 0;
  localparam int unsigned SEFL_BIT_CLAMP    = 1;
  localparam int unsigned SEFL_BIT_OVERVOLT = 2;
  localparam int unsigned SEFL_BIT_GAIN     = 3;
  localparam int unsigned SEFL_BIT_CHECKSUM = 4;
  // Register numbers of the status and delay registers
  localparam logic [3:0] SEFL_REG_STATUS = 4'h4;
  localparam logic [3:0] SEFL_REG_DELAY  = 4'hB;
  // Reset values
  localparam logic [4:0] SEFL_STATUS_RST = 5'h00;
  localparam logic       SEFL_GAIN_RST   = 1'b0; // 0 = 1 V/V, 1 = 1.375 V/V
  localparam int unsigned SEFL_DELAY_W   = 8;

  // Raw sensor inputs grouped
  typedef struct packed {
    logic checksum;
    logic gain;
    logic overvolt;
    logic clamp;
    logic output_fault;
  } sefl_raw_t;
endpackage
`default_nettype wire

// ===== sefl_flags.sv
`default_nettype none
module sefl_flags
  import sefl_pkg::*;
#(
  parameter int unsigned DELAY_W = SEFL_DELAY_W
)(
  input  wire logic                 clk_i,
  input  wire logic                 reset_n_i,
  input  wire logic                 out_clip_p_i,
  input  wire logic                 out_clip_n_i,
  input  wire logic                 out_ovc_p_i,
  input  wire logic                 out_ovc_n_i,
  input  wire logic                 clamp_i,
  input  wire logic                 overvolt_i,
  input  wire logic                 gain_ovl_i,
  input  wire logic                 checksum_err_i,
  input  wire logic                 checksum_mode_i,
  input  wire logic                 buffer_run_i,
  input  wire logic                 suppress_en_i,
  input  wire logic                 latch_disable_i,
  input  wire logic [DELAY_W-1:0]   delay_i,
  input  wire logic                 gain_wr_i,
  input  wire logic                 gain_sel_i,
  input  wire logic [SEFL_NFLAG-1:0] clear_i,
  input  wire logic [SEFL_NFLAG-1:0] mask_i,
  output logic [SEFL_NFLAG-1:0]     status_o,
  output logic                      error_pin_o,
  output logic                      buffer_active_o,
  output logic                      gain_factor_o
);

  // ----------------------------------------
  // Helper functions
  // ----------------------------------------
  // Any monitor of either output pin counts as one output fault
  function automatic logic out_fault(
    input logic [3:0] mon
  );
    return |mon;
  endfunction

  // Next count of one filter; any gap restarts the wait, and the
  // count parks at the delay so it can never wrap while a fault stands
  function automatic logic [DELAY_W-1:0] filt_count(
    input logic               level,
    input logic [DELAY_W-1:0] count,
    input logic [DELAY_W-1:0] delay
  );
    logic [DELAY_W-1:0] result;
    result = count;
    if (!level)
      result = '0;
    else if (count < delay)
      result = DELAY_W'(count + 1'h1);
    return result;
  endfunction

  // A filter passes once the level has stood for the full delay
  function automatic logic filt_pass(
    input logic               level,
    input logic [DELAY_W-1:0] count,
    input logic [DELAY_W-1:0] delay
  );
    return level && (count >= delay);
  endfunction

  // Unless follow is set, held flags lose only the bits written with one; a fault present
  // in the same cycle wins over its own clear, so none is ever missed
  function automatic logic [SEFL_NFLAG-1:0] status_step(
    input logic                  follow,
    input logic [SEFL_NFLAG-1:0] held,
    input logic [SEFL_NFLAG-1:0] wipe,
    input logic [SEFL_NFLAG-1:0] hit
  );
    logic [SEFL_NFLAG-1:0] result;
    if (follow)
      result = hit;
    else
      result = (held & ~wipe) | hit;
    return result;
  endfunction

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Eight sensor levels and the buffer run level
  localparam int unsigned NSYNC = 9;

  logic [NSYNC-1:0] raw_pins;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] next_sync1;
  logic [NSYNC-1:0] next_sync2;

  // Pin order sets the bit positions decoded further down
  assign raw_pins = {buffer_run_i, checksum_err_i, gain_ovl_i, overvolt_i,
                     clamp_i, out_ovc_n_i, out_ovc_p_i, out_clip_n_i,
                     out_clip_p_i};

  // Comparators are asynchronous to clk; only stage two reads stage one
  always_comb
  begin
    next_sync1 = raw_pins;
    next_sync2 = sync1;
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= next_sync1;
      sync2 <= next_sync2;
    end
  end

  // ----------------------------------------
  // Raw condition gathering
  // ----------------------------------------
  sefl_raw_t raw;
  logic      buf_act;

  // Buffer level feeds only suppression and the busy output
  assign buf_act = sync2[8];
  // Both outputs watched even when one is unused
  assign raw.output_fault = out_fault(sync2[3:0]);
  assign raw.clamp        = sync2[4];
  assign raw.overvolt     = sync2[5];
  assign raw.gain         = sync2[6];
  // Gated before the filter, so its counter idles with the mode off
  assign raw.checksum     = sync2[7] & checksum_mode_i;

  // ----------------------------------------
  // Buffer suppression
  // ----------------------------------------
  logic [SEFL_NFLAG-1:0] masked;

  // Buffer transients would falsely trip the sensors, so while the
  // buffer runs and suppression is on nothing reaches the filters
  always_comb
  begin
    masked = raw;
    if (suppress_en_i && buf_act)
      masked = 5'h00;
  end

  // ----------------------------------------
  // Suppression delay filters
  // ----------------------------------------
  logic [SEFL_NFLAG-1:0] filtered;
  logic [DELAY_W-1:0]    cnt [SEFL_NFLAG];
  logic [DELAY_W-1:0]    next_cnt [SEFL_NFLAG];

  // One counter per flag; a one-cycle gap restarts it, so short
  // pulses vanish at the cost of losing a chattering fault
  always_comb
  begin
    for (int i = 0; i < SEFL_NFLAG; i++)
    begin
      next_cnt[i] = filt_count(masked[i], cnt[i], delay_i);
      filtered[i] = filt_pass(masked[i], cnt[i], delay_i);
    end
  end

  // Counters start idle so no flag can follow reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      for (int i = 0; i < SEFL_NFLAG; i++)
        cnt[i] <= '0;
    end
    else
    begin
      for (int i = 0; i < SEFL_NFLAG; i++)
        cnt[i] <= next_cnt[i];
    end
  end

  // ----------------------------------------
  // Status register
  // ----------------------------------------
  logic [SEFL_NFLAG-1:0] status;
  logic [SEFL_NFLAG-1:0] next_status;

  // Latched unless latch-disable, then it follows the filters
  always_comb
  begin
    next_status = status_step(latch_disable_i, status, clear_i,
                              filtered);
  end

  // Only reset, a written one or latch-disable takes a held flag away
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      status <= SEFL_STATUS_RST;
    else
      status <= next_status;
  end

  assign status_o = status;

  // ----------------------------------------
  // Error pin
  // ----------------------------------------
  logic err_pin;
  logic next_err_pin;

  // Built from the next flags so the pin moves on the same edge
  // as the status word, never a cycle behind it
  always_comb
  begin
    next_err_pin = |(next_status & mask_i);
  end

  // Pin is quiet through reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      err_pin <= 1'h0;
    else
      err_pin <= next_err_pin;
  end

  assign error_pin_o = err_pin;

  // ----------------------------------------
  // Buffer busy indication
  // ----------------------------------------
  logic buf_q;
  logic next_buf;

  // Busy follows the synchronised run level; one extra stage keeps
  // the output registered
  always_comb
  begin
    next_buf = buf_act;
  end

  // Busy reads idle through reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      buf_q <= 1'h0;
    else
      buf_q <= next_buf;
  end

  assign buffer_active_o = buf_q;

  // ----------------------------------------
  // Output gain factor
  // ----------------------------------------
  logic gain_q;
  logic next_gain;

  // Only a write strobe moves the factor; a select that changes
  // without a strobe is ignored
  always_comb
  begin
    next_gain = gain_q;
    if (gain_wr_i)
      next_gain = gain_sel_i;
  end

  // Unity factor after every reset
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      gain_q <= SEFL_GAIN_RST;
    else
      gain_q <= next_gain;
  end

  assign gain_factor_o = gain_q;

endmodule
`default_nettype wire

// ===== sefl_properties.sv
`default_nettype none
// ----------------
// Flag checker
// ----------------
module sefl_properties
  import sefl_pkg::*;
(
  input wire logic       clk_i,
  input wire logic       reset_n_i,
  input wire logic       clamp_i,
  input wire logic       checksum_mode_i,
  input wire logic       suppress_en_i,
  input wire logic       latch_disable_i,
  input wire logic       buffer_run_i,
  input wire logic       gain_wr_i,
  input wire logic       gain_sel_i,
  input wire logic [4:0] clear_i,
  input wire logic [4:0] mask_i,
  input wire logic [4:0] status_o,
  input wire logic       error_pin_o,
  input wire logic       buffer_active_o,
  input wire logic       gain_factor_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // Mask changes are skipped, the pin may lag them
  pin_or_a: assert property ($stable(mask_i) |->
    error_pin_o == |(status_o & mask_i)) else $error("pin wrong");
  gain_hold_a: assert property (!$past(gain_wr_i) |->
    $stable(gain_factor_o)) else $error("gain moved");
  gain_load_a: assert property (gain_wr_i |=>
    gain_factor_o == $past(gain_sel_i)) else $error("gain not loaded");
  filt_need_a: assert property ($rose(status_o[1]) |->
    $past(clamp_i, 3)) else $error("flag without filter");
  flag_hold_a: assert property (status_o[1] && !clear_i[1] &&
    !latch_disable_i |=> status_o[1]) else $error("flag lost");
  flag_clear_a: assert property (clear_i[1] && !clamp_i &&
    !$past(clamp_i) && !$past(clamp_i, 2) |=> !status_o[1])
    else $error("no clear");
  buf_lat_a: assert property (buffer_active_o ==
    $past(buffer_run_i, 3)) else $error("busy wrong");
  chk_off_a: assert property (!checksum_mode_i &&
    !$past(checksum_mode_i) && !$past(checksum_mode_i, 2) &&
    !$past(checksum_mode_i, 3) |-> !$rose(status_o[4]))
    else $error("checksum flag");
  buf_suppress_a: assert property (suppress_en_i && buffer_active_o &&
    $past(buffer_active_o) |-> !$rose(status_o[1]))
    else $error("no suppress");
endmodule
bind sefl_flags sefl_properties i_prop (.clk_i, .reset_n_i, .clamp_i,
  .checksum_mode_i, .suppress_en_i, .latch_disable_i, .buffer_run_i,
  .gain_wr_i, .gain_sel_i, .clear_i, .mask_i, .status_o, .error_pin_o,
  .buffer_active_o, .gain_factor_o);
`default_nettype wire

// ===== tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sefl_pkg::*;
  // ----------------
  // Stimulus and DUT
  // ----------------
  logic       clk_i      = 1'h0;
  logic       reset_n_i  = 1'h0;
  logic       mode       = 1'h0;
  logic       brun       = 1'h0;
  logic       ld         = 1'h0;
  logic       sup        = 1'h1;
  logic       gw         = 1'h0;
  logic       gs         = 1'h0;
  logic       pin;
  logic       ba;
  logic       gf;
  logic [7:0] raw        = 8'h00;
  logic [7:0] dly        = 8'h02;
  logic [4:0] clr        = 5'h00;
  logic [4:0] msk        = 5'h1F;
  logic [4:0] st;
  int         n_fail     = 0;
  int         num_checks = 0;
  // Short delay keeps each flag walk brief
  sefl_flags i_dut (.clk_i, .reset_n_i, .out_clip_p_i(raw[0]),
    .out_clip_n_i(raw[1]), .out_ovc_p_i(raw[2]), .out_ovc_n_i(raw[3]),
    .clamp_i(raw[4]), .overvolt_i(raw[5]), .gain_ovl_i(raw[6]),
    .checksum_err_i(raw[7]), .checksum_mode_i(mode), .buffer_run_i(brun),
    .suppress_en_i(sup), .latch_disable_i(ld), .delay_i(dly),
    .gain_wr_i(gw), .gain_sel_i(gs), .clear_i(clr), .mask_i(msk),
    .status_o(st), .error_pin_o(pin), .buffer_active_o(ba),
    .gain_factor_o(gf));
  always #20 clk_i = ~clk_i;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Raise one sensor for n cycles, then let the pipe settle
  task automatic fire(input int i, input int n);
    @(posedge clk_i) raw[i] <= 1'h1;
    cyc(n);
    raw[i] <= 1'h0;
    cyc(5);
  endtask
  task automatic wipe;
    @(posedge clk_i) clr <= 5'h1F;
    @(posedge clk_i) clr <= 5'h00;
    cyc(1);
    #1 chk(8'(st), 8'h00);
  endtask
  // Outputs start at zero and the gain at unity
  task automatic test_reset;
    cyc(5);
    reset_n_i <= 1'h1;
    cyc(1);
    #1 chk({st, pin, ba, gf}, 8'h00);
    $display("test reset done");
  endtask
  // A pulse must outlast the programmed delay by one sampled cycle
  task automatic test_filter;
    fire(4, 1);
    #1 chk(8'(st), 8'h00);
    @(posedge clk_i) dly <= 8'h05;
    fire(4, 5);
    #1 chk(8'(st), 8'h00);
    fire(4, 6);
    #1 chk(8'(st), 8'h02);
    wipe();
    @(posedge clk_i) dly <= 8'h02;
    $display("test filter done");
  endtask
  // Every sensor sets its flag and the pin; the four output monitors share one flag
  task automatic test_sources;
    logic [7:0] want;
    @(posedge clk_i) mode <= 1'h1;
    for (int i = 0; i < 8; i++)
    begin
      fire(i, 6);
      want = 8'h20 | (8'h01 << (i < 4 ? 0 : i - 3));
      #1 chk(8'({pin, st}), want);
      wipe();
    end
    $display("test sources done");
  endtask
  // Checksum off is ignored; a masked flag stays off the pin
  task automatic test_masks;
    @(posedge clk_i)
    begin
      mode <= 1'h0;
      msk  <= 5'h1D;
    end
    fire(7, 6);
    fire(4, 6);
    #1 chk(8'({pin, st}), 8'h02);
    @(posedge clk_i) msk <= 5'h1F;
    cyc(1);
    #1 chk(8'(pin), 8'h01);
    wipe();
    $display("test masks done");
  endtask
  // A clear during a standing fault loses; the flag outlives its cause
  task automatic test_collide;
    @(posedge clk_i) raw[4] <= 1'h1;
    cyc(6);
    clr <= 5'h02;
    @(posedge clk_i) clr <= 5'h00;
    cyc(1);
    #1 chk(8'(st), 8'h02);
    @(posedge clk_i) raw[4] <= 1'h0;
    cyc(5);
    #1 chk(8'(st), 8'h02);
    wipe();
    $display("test collide done");
  endtask
  // With latch-disable the flag rises and then follows the sensor down
  task automatic test_latch;
    @(posedge clk_i) ld <= 1'h1;
    @(posedge clk_i) raw[5] <= 1'h1;
    cyc(6);
    raw[5] <= 1'h0;
    #1 chk(8'(st), 8'h04);
    cyc(5);
    #1 chk(8'(st), 8'h00);
    @(posedge clk_i) ld <= 1'h0;
    $display("test latch done");
  endtask
  // Busy follows the buffer; suppression only while enabled
  task automatic test_buffer;
    @(posedge clk_i) brun <= 1'h1;
    cyc(4);
    #1 chk(8'(ba), 8'h01);
    fire(4, 6);
    #1 chk(8'(st), 8'h00);
    @(posedge clk_i) sup <= 1'h0;
    fire(4, 6);
    #1 chk(8'(st), 8'h02);
    wipe();
    @(posedge clk_i)
    begin
      brun <= 1'h0;
      sup  <= 1'h1;
    end
    cyc(4);
    #1 chk(8'(ba), 8'h00);
    $display("test buffer done");
  endtask
  // Factor moves only on a strobe, both ways
  task automatic test_gain;
    @(posedge clk_i)
    begin
      gs <= 1'h1;
      gw <= 1'h1;
    end
    @(posedge clk_i) gw <= 1'h0;
    cyc(1);
    #1 chk(8'(gf), 8'h01);
    @(posedge clk_i) gs <= 1'h0;
    cyc(2);
    #1 chk(8'(gf), 8'h01);
    @(posedge clk_i) gw <= 1'h1;
    @(posedge clk_i) gw <= 1'h0;
    cyc(1);
    #1 chk(8'(gf), 8'h00);
    $display("test gain done");
  endtask
  // A reset in mid-run drops a held flag and the raised gain
  task automatic test_midreset;
    fire(5, 6);
    @(posedge clk_i)
    begin
      gs <= 1'h1;
      gw <= 1'h1;
    end
    @(posedge clk_i) gw <= 1'h0;
    cyc(1);
    #1 chk({st, pin, ba, gf}, 8'h25);
    @(posedge clk_i) reset_n_i <= 1'h0;
    #1 chk({st, pin, ba, gf}, 8'h00);
    cyc(3);
    reset_n_i <= 1'h1;
    cyc(2);
    #1 chk({st, pin, ba, gf}, 8'h00);
    @(posedge clk_i) gs <= 1'h0;
    $display("test midreset done");
  endtask
  task automatic complete_run;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Watchdog: the tests need some three hundred cycles
  initial
  begin
    cyc(2000);
    n_fail++;
    complete_run();
  end
  initial
  begin
    test_reset();
    test_filter();
    test_sources();
    test_masks();
    test_collide();
    test_latch();
    test_buffer();
    test_gain();
    test_midreset();
    complete_run();
  end
endmodule
`default_nettype wire
